// file: rtl/aut_top.sv
// aut_top: segment and page address translation with apb control registers.
// assumes core requests are one-cycle pulses taken only while busy_q is low,
// and a memory port whose read data is valid only in the mem_ack cycle.
`default_nettype none
module aut_top
  import aut_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic seg_load,
  input wire logic [2:0] seg_idx,
  input wire logic [15:0] seg_sel,
  input wire logic xl_req,
  input wire logic xl_write,
  input wire logic [31:0] xl_off,
  output logic xl_busy,
  output logic xl_done,
  output logic [31:0] xl_paddr,
  output logic xl_gp_fault,
  output logic xl_limit_fault,
  output logic xl_page_fault,
  output logic xl_nocache,
  // memory side
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // software registers
  logic [4:0] ctrl_q;
  logic [31:0] dirbase_q;
  logic [31:0] gdtbase_q;
  logic [31:0] ldtbase_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  // segment cache
  logic [15:0] sel_q [AUT_NSEG];
  logic [31:0] base_q [AUT_NSEG];
  logic [19:0] limit_q [AUT_NSEG];
  logic [7:0] attr_q [AUT_NSEG];
  // walk state
  aut_state_t st_q;
  logic [2:0] cur_seg_q;
  logic [31:0] lin_q;
  logic wr_q;
  logic [31:0] w0_q;
  logic [31:0] pde_q;
  logic [31:0] tent_q;
  logic busy_q;
  logic done_q;
  logic [31:0] paddr_q;
  logic gp_q;
  logic lim_q;
  logic pf_q;
  logic nc_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [31:0] mem_addr_q;
  logic [31:0] mem_wdata_q;

  // control decode
  wire prot = ctrl_q[AUT_CTRL_PROT_BIT];
  wire paging = ctrl_q[AUT_CTRL_PAGE_BIT];
  wire wide = ctrl_q[AUT_CTRL_WIDE_BIT];
  wire [1:0] priv = ctrl_q[AUT_CTRL_PRIV_LSB +: 2];

  // apb decode
  wire apb_setup = psel & ~penable & ~pready_q;
  wire apb_wr = psel & penable & pready_q & pwrite;
  wire hit_ctrl = paddr == AUT_CTRL_OFS;
  wire hit_dir = paddr == AUT_DIRBASE_OFS;
  wire hit_glob = paddr == AUT_GDTBASE_OFS;
  wire hit_loc = paddr == AUT_LDTBASE_OFS;
  wire hit_st = paddr == AUT_STATUS_OFS;
  wire hit_pa = paddr == AUT_PADDR_OFS;
  wire hit_any = hit_ctrl | hit_dir | hit_glob | hit_loc | hit_st | hit_pa;
  wire [31:0] status_w = {27'h0, nc_q, pf_q, lim_q, gp_q, busy_q};
  wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                       hit_dir ? dirbase_q :
                       hit_glob ? gdtbase_q :
                       hit_loc ? ldtbase_q :
                       hit_st ? status_w :
                       hit_pa ? paddr_q : 32'h0000_0000;

  // real mode address
  wire [15:0] rseg = sel_q[seg_idx];
  wire [20:0] real_sum = {1'b0, rseg, 4'h0} + {5'h00, xl_off[15:0]};
  wire [31:0] real_pa = wide ? {11'h000, real_sum} :
                        {11'h000, real_sum} & 32'h00FF_FFFF;
  wire real_gp = xl_off[31:16] != AUT_OFS_MAX_HI;
  wire real_lim = real_sum[20];

  // protected linear address from cached base
  wire [31:0] lin_w = base_q[seg_idx] + xl_off;

  // descriptor fetch address
  wire [31:0] tbl_base = seg_sel[2] ? ldtbase_q : gdtbase_q;
  wire [31:0] desc_addr = tbl_base + {16'h0000, seg_sel[15:3], 3'h0};
  wire [31:0] desc_base = {mem_rdata[31:24], mem_rdata[7:0], w0_q[31:16]};
  wire [19:0] desc_limit = {mem_rdata[19:16], w0_q[15:0]};

  // page walk addresses
  wire [31:0] lin_walk = lin_w;
  wire [31:0] pde_addr = {dirbase_q[31:12], lin_walk[31:22], 2'h0};
  wire [31:0] tent_addr = {mem_rdata[31:12], lin_q[21:12], 2'h0};
  wire [31:0] tent_addr_q = {pde_q[31:12], lin_q[21:12], 2'h0};

  // entry checks on the word being returned
  wire e_absent = ~mem_rdata[AUT_E_P];
  wire e_user_bad = (priv == AUT_USER_PRIV) & ~mem_rdata[AUT_E_U];
  wire e_wr_bad = wr_q & ~mem_rdata[AUT_E_W];
  wire e_fault = e_absent | e_user_bad | e_wr_bad;
  wire pde_need = ~mem_rdata[AUT_E_A];
  wire [31:0] pde_new = mem_rdata | (32'h1 << AUT_E_A);
  wire tent_need = ~mem_rdata[AUT_E_A] | (wr_q & ~mem_rdata[AUT_E_D]);
  wire [31:0] tent_set = (32'h1 << AUT_E_A) | (wr_q ? (32'h1 << AUT_E_D) : 32'h0);
  wire [31:0] tent_new = mem_rdata | tent_set;
  wire [31:0] page_pa = {mem_rdata[31:12], lin_q[11:0]};
  wire [31:0] page_pa_q = {tent_q[31:12], lin_q[11:0]};
  wire page_nc = pde_q[AUT_E_NC] | mem_rdata[AUT_E_NC];
  wire page_nc_q = pde_q[AUT_E_NC] | tent_q[AUT_E_NC];

  // output assignments
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign xl_busy = busy_q;
  assign xl_done = done_q;
  assign xl_paddr = paddr_q;
  assign xl_gp_fault = gp_q;
  assign xl_limit_fault = lim_q;
  assign xl_page_fault = pf_q;
  assign xl_nocache = nc_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;

  // apb slave: no wait cycle, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~hit_any;
      if (apb_setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= AUT_CTRL_RST;
      dirbase_q <= AUT_BASE_RST;
      gdtbase_q <= AUT_BASE_RST;
      ldtbase_q <= AUT_BASE_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        ctrl_q <= pwdata[4:0];
      end
      if (hit_dir) begin
        dirbase_q <= {pwdata[31:12], 12'h000};
      end
      if (hit_glob) begin
        gdtbase_q <= pwdata;
      end
      if (hit_loc) begin
        ldtbase_q <= pwdata;
      end
    end
  end

  // segment cache, one entry per register
  for (genvar g = 0; g < AUT_NSEG; g++) begin : g_seg
    wire ld_real = (st_q == AUT_IDLE) & seg_load & ~prot & (seg_idx == 3'(g));
    wire ld_prot = (st_q == AUT_DESC1) & mem_ack & (cur_seg_q == 3'(g));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sel_q[g] <= 16'h0000;
        base_q[g] <= AUT_BASE_RST;
        limit_q[g] <= 20'h0FFFF;
        attr_q[g] <= 8'h00;
      end else if (ld_real) begin
        sel_q[g] <= seg_sel;
        base_q[g] <= {12'h000, seg_sel, 4'h0};
      end else if (ld_prot) begin
        base_q[g] <= desc_base;
        limit_q[g] <= desc_limit;
        attr_q[g] <= mem_rdata[15:8];
      end
    end
  end

  // translation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= AUT_IDLE;
      cur_seg_q <= 3'h0;
      lin_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      w0_q <= 32'h0000_0000;
      pde_q <= 32'h0000_0000;
      tent_q <= 32'h0000_0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      paddr_q <= 32'h0000_0000;
      gp_q <= 1'b0;
      lim_q <= 1'b0;
      pf_q <= 1'b0;
      nc_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      mem_wdata_q <= 32'h0000_0000;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        AUT_IDLE: begin
          if (seg_load) begin
            cur_seg_q <= seg_idx;
            if (prot) begin
              st_q <= AUT_DESC0;
              busy_q <= 1'b1;
              mem_req_q <= 1'b1;
              mem_we_q <= 1'b0;
              mem_addr_q <= desc_addr;
            end else begin
              done_q <= 1'b1;
            end
          end else if (xl_req) begin
            lin_q <= lin_w;
            wr_q <= xl_write;
            gp_q <= 1'b0;
            lim_q <= 1'b0;
            pf_q <= 1'b0;
            nc_q <= 1'b0;
            if (!prot) begin
              done_q <= 1'b1;
              paddr_q <= real_pa;
              gp_q <= real_gp;
              lim_q <= real_lim & ~real_gp;
            end else if (!paging) begin
              done_q <= 1'b1;
              paddr_q <= lin_w;
            end else begin
              st_q <= AUT_PDE;
              busy_q <= 1'b1;
              mem_req_q <= 1'b1;
              mem_we_q <= 1'b0;
              mem_addr_q <= pde_addr;
            end
          end
        end
        AUT_DESC0: begin
          if (mem_ack) begin
            w0_q <= mem_rdata;
            mem_addr_q <= mem_addr_q + AUT_WORD_STEP;
            st_q <= AUT_DESC1;
          end
        end
        AUT_DESC1: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= AUT_IDLE;
          end
        end
        AUT_PDE: begin
          if (mem_ack) begin
            pde_q <= mem_rdata;
            if (e_fault) begin
              mem_req_q <= 1'b0;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              pf_q <= 1'b1;
              st_q <= AUT_IDLE;
            end else if (pde_need) begin
              mem_we_q <= 1'b1;
              mem_wdata_q <= pde_new;
              st_q <= AUT_PDEWB;
            end else begin
              mem_addr_q <= tent_addr;
              st_q <= AUT_TBL;
            end
          end
        end
        AUT_PDEWB: begin
          if (mem_ack) begin
            mem_we_q <= 1'b0;
            mem_addr_q <= tent_addr_q;
            st_q <= AUT_TBL;
          end
        end
        AUT_TBL: begin
          if (mem_ack) begin
            tent_q <= mem_rdata;
            if (e_fault) begin
              mem_req_q <= 1'b0;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              pf_q <= 1'b1;
              st_q <= AUT_IDLE;
            end else if (tent_need) begin
              mem_we_q <= 1'b1;
              mem_wdata_q <= tent_new;
              st_q <= AUT_TBLWB;
            end else begin
              mem_req_q <= 1'b0;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              paddr_q <= page_pa;
              nc_q <= page_nc;
              st_q <= AUT_IDLE;
            end
          end
        end
        AUT_TBLWB: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            paddr_q <= page_pa_q;
            nc_q <= page_nc_q;
            st_q <= AUT_IDLE;
          end
        end
        default: begin
          st_q <= AUT_IDLE;
          busy_q <= 1'b0;
          mem_req_q <= 1'b0;
          mem_we_q <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/aut_pkg.sv
// aut_pkg: constants shared by the address translation unit.
// assumes a 32-bit apb register bus and a 32-bit word memory port.
`default_nettype none
package aut_pkg;
  // apb register byte offsets
  localparam logic [7:0] AUT_CTRL_OFS = 8'h00;
  localparam logic [7:0] AUT_DIRBASE_OFS = 8'h04;
  localparam logic [7:0] AUT_GDTBASE_OFS = 8'h08;
  localparam logic [7:0] AUT_LDTBASE_OFS = 8'h0C;
  localparam logic [7:0] AUT_STATUS_OFS = 8'h10;
  localparam logic [7:0] AUT_PADDR_OFS = 8'h14;
  // control fields
  localparam int AUT_CTRL_PROT_BIT = 0;
  localparam int AUT_CTRL_PAGE_BIT = 1;
  localparam int AUT_CTRL_WIDE_BIT = 2;
  localparam int AUT_CTRL_PRIV_LSB = 3;
  localparam logic [4:0] AUT_CTRL_RST = 5'h00;
  localparam logic [31:0] AUT_BASE_RST = 32'h0000_0000;
  // status fields
  localparam int AUT_ST_BUSY_BIT = 0;
  localparam int AUT_ST_GP_BIT = 1;
  localparam int AUT_ST_LIM_BIT = 2;
  localparam int AUT_ST_PF_BIT = 3;
  localparam int AUT_ST_NC_BIT = 4;
  // table entry fields
  localparam int AUT_E_P = 0;
  localparam int AUT_E_W = 1;
  localparam int AUT_E_U = 2;
  localparam int AUT_E_NC = 4;
  localparam int AUT_E_A = 5;
  localparam int AUT_E_D = 6;
  localparam int AUT_PAGE_BITS = 12;
  localparam int AUT_NSEG = 6;
  localparam logic [1:0] AUT_USER_PRIV = 2'h3;
  localparam logic [31:0] AUT_WORD_STEP = 32'h0000_0004;
  localparam logic [15:0] AUT_OFS_MAX_HI = 16'h0000;
  typedef enum logic [2:0] {
    AUT_IDLE = 3'b000,
    AUT_DESC0 = 3'b001,
    AUT_DESC1 = 3'b010,
    AUT_PDE = 3'b011,
    AUT_PDEWB = 3'b100,
    AUT_TBL = 3'b101,
    AUT_TBLWB = 3'b110
  } aut_state_t;
endpackage
`default_nettype wire

// file: testbench/aut_top_props.sv
// aut_top_props: concurrent checks on the translation unit ports.
// assumes binding into aut_top; tracks control writes and segment loads itself.
`default_nettype none
module aut_top_props
  import aut_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // core
  input wire logic seg_load,
  input wire logic [2:0] seg_idx,
  input wire logic [15:0] seg_sel,
  input wire logic xl_req,
  input wire logic [31:0] xl_off,
  input wire logic xl_busy,
  input wire logic xl_done,
  input wire logic [31:0] xl_paddr,
  input wire logic xl_gp_fault,
  input wire logic xl_limit_fault,
  // memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] seg_q [8];
  logic [2:0] ctrl_q;
  logic [19:0] dir_q;
  logic [20:0] rsum_q;
  wire logic take = xl_req && !xl_busy && !seg_load;
  wire logic wr = psel && penable && pready && pwrite;
  wire logic rmode = take && !ctrl_q[AUT_CTRL_PROT_BIT];
  wire logic real_ok = rmode && xl_off[31:16] == 16'h0000;
  wire logic real_gp = rmode && xl_off[31:16] != 16'h0000;
  wire logic walk = take && ctrl_q[AUT_CTRL_PROT_BIT] && ctrl_q[AUT_CTRL_PAGE_BIT];
  wire logic [20:0] rsum = {1'b0, seg_q[seg_idx], 4'h0} + {5'h00, xl_off[15:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h0;
      dir_q <= 20'h00000;
      rsum_q <= 21'h000000;
      seg_q <= '{default: 16'h0000};
    end else begin
      if (wr && paddr == AUT_CTRL_OFS) ctrl_q <= pwdata[2:0];
      if (wr && paddr == AUT_DIRBASE_OFS) dir_q <= pwdata[31:12];
      if (seg_load && !xl_busy) seg_q[seg_idx] <= seg_sel;
      if (take) rsum_q <= rsum;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  AST_APB_READY:
  assert property (s_setup |=> s_answer) else $error("apb access phase not one cycle");
  AST_SLVERR_READY:
  assert property (pslverr |-> pready) else $error("error response without ready");
  AST_REAL_ADDR:
  assert property (real_ok |-> ##[1:2] (xl_done && xl_paddr == {11'h000, rsum_q}))
    else $error("real mode address wrong");
  AST_REAL_LIMIT:
  assert property (real_ok |-> ##[1:2] (xl_done && xl_limit_fault == rsum_q[20] && !xl_gp_fault))
    else $error("real mode limit flag wrong");
  AST_REAL_GP:
  assert property (real_gp |-> ##[1:2] (xl_done && xl_gp_fault && !xl_limit_fault))
    else $error("large offset not refused");
  AST_DIR_BASE:
  assert property (walk |-> ##[1:2] (mem_req && mem_addr[31:12] == dir_q && mem_addr[1:0] == 2'h0))
    else $error("walk does not start at directory");
  AST_WB_ACCESSED:
  assert property (mem_req && mem_we |-> mem_wdata[AUT_E_A] && mem_wdata[AUT_E_P])
    else $error("entry written back without accessed");
  AST_MEM_HOLD:
  assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  AST_DONE_PULSE:
  assert property (xl_done |=> !xl_done) else $error("done longer than one cycle");
  AST_WALK_BUSY:
  assert property (walk |=> (xl_busy && mem_req && !mem_we))
    else $error("walk started without busy read");
endmodule
bind aut_top aut_top_props aut_top_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .seg_load, .seg_idx, .seg_sel, .xl_req, .xl_off, .xl_busy,
  .xl_done, .xl_paddr, .xl_gp_fault, .xl_limit_fault, .mem_req, .mem_we, .mem_addr,
  .mem_wdata, .mem_ack);
`default_nettype wire

// file: testbench/aut_mem_model.sv
// aut_mem_model: word memory holding descriptors and page tables.
// assumes requests held until mem_ack; slow adds three wait cycles.
`default_nettype none
module aut_mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [29:0]];
  int wait_n;
  // data lines toggle whenever no read answer stands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_n = 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && wait_n < (slow ? 3 : 0)) begin
        wait_n++;
      end else if (mem_req && !mem_ack) begin
        wait_n = 0;
        mem_ack <= 1'b1;
        if (mem_we)
          mem[mem_addr[31:2]] = mem_wdata;
        else
          mem_rdata <= mem.exists(mem_addr[31:2]) ? mem[mem_addr[31:2]] : 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/aut_top_bench.sv
// aut_top_bench: register, real, protected and paging scenarios.
// assumes aut_top with the checker bound and aut_mem_model as memory.
`default_nettype none
module aut_top_bench;
  import aut_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic seg_load = 1'b0, xl_req = 1'b0, xl_write = 1'b0, slow = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [2:0] seg_idx = 3'h0;
  logic [15:0] seg_sel = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, xl_off = 32'h0000_0000, rd;
  logic [31:0] prdata, xl_paddr, mem_addr, mem_wdata, mem_rdata;
  logic pready, pslverr, xl_busy, xl_done, xl_gp_fault, xl_limit_fault, xl_page_fault;
  logic xl_nocache, mem_req, mem_we, mem_ack;
  int miscompares = 0, n_tests = 0;
  always #12.5 pclk = ~pclk;
  aut_top aut_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .seg_load, .seg_idx, .seg_sel, .xl_req, .xl_write, .xl_off, .xl_busy,
    .xl_done, .xl_paddr, .xl_gp_fault, .xl_limit_fault, .xl_page_fault, .xl_nocache,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  aut_mem_model aut_mem_model_i (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .slow, .mem_ack, .mem_rdata);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic poke(input logic [31:0] a, input logic [31:0] d);
    aut_mem_model_i.mem[a[31:2]] = d;
  endtask
  function automatic logic [31:0] peek(input logic [31:0] a);
    return aut_mem_model_i.mem[a[31:2]];
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ld selects a segment load, else a translation of v
  task automatic xl(input logic ld, input logic w, input logic [2:0] i, input logic [31:0] v);
    @(posedge pclk);
    seg_load <= ld;
    xl_req <= !ld;
    xl_write <= w;
    seg_idx <= i;
    seg_sel <= v[15:0];
    xl_off <= v;
    @(posedge pclk);
    seg_load <= 1'b0;
    xl_req <= 1'b0;
    repeat (100) begin
      @(posedge pclk);
      if (xl_done === 1'b1) break;
    end
    chk(xl_done, 1'b1, "no done");
  endtask
  task automatic rl(input logic [15:0] s, input logic [31:0] o, input logic [31:0] pa,
                    input logic gp, input logic lim);
    xl(1'b1, 1'b0, 3'h1, {16'h0000, s});
    xl(1'b0, 1'b0, 3'h1, o);
    chk(xl_gp_fault, gp, "gp fault");
    chk(xl_limit_fault, lim, "limit fault");
    if (!gp) chk(xl_paddr, pa, "real address");
  endtask
  task automatic pg(input logic [4:0] c, input logic w, input logic [31:0] o, input logic pf,
                    input logic [31:0] pa);
    apb(1'b1, AUT_CTRL_OFS, {27'h0, c});
    xl(1'b0, w, 3'h3, o);
    chk(xl_page_fault, pf, "page fault");
    if (!pf) chk(xl_paddr, pa, "paged address");
  endtask
  task automatic t_regs();
    apb(1'b0, AUT_CTRL_OFS, 32'h0);
    chk(rd, {27'h0, AUT_CTRL_RST}, "ctrl reset");
    apb(1'b1, AUT_DIRBASE_OFS, 32'h0001_2FFF);
    apb(1'b0, AUT_DIRBASE_OFS, 32'h0);
    chk(rd, 32'h0001_2000, "dir base aligned");
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk(err, 1'b1, "unmapped write");
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, AUT_PADDR_OFS, 32'h1234_5678);
    apb(1'b0, AUT_PADDR_OFS, 32'h0);
    chk(rd, 32'h0, "read-only result");
    $display("registers done");
  endtask
  task automatic t_real();
    rl(16'h1234, 32'h0000_0010, 32'h0001_2350, 1'b0, 1'b0);
    rl(16'h0000, 32'h0000_FFFF, 32'h0000_FFFF, 1'b0, 1'b0);
    rl(16'h0000, 32'h0001_0000, 32'h0, 1'b1, 1'b0);
    rl(16'hFFFF, 32'h0000_0010, 32'h0010_0000, 1'b0, 1'b1);
    apb(1'b1, AUT_CTRL_OFS, 32'h4);
    rl(16'hFFFF, 32'h0000_FFFF, 32'h0010_FFEF, 1'b0, 1'b1);
    $display("real mode done");
  endtask
  task automatic t_prot();
    poke(32'h1010, 32'h5000_FFFF);
    poke(32'h1014, 32'h0000_0040);
    poke(32'h2008, 32'h8000_FFFF);
    poke(32'h200C, 32'h1200_0034);
    apb(1'b1, AUT_GDTBASE_OFS, 32'h1000);
    apb(1'b1, AUT_LDTBASE_OFS, 32'h2000);
    apb(1'b1, AUT_CTRL_OFS, 32'h1);
    xl(1'b1, 1'b0, 3'h3, 32'h0010);
    xl(1'b1, 1'b0, 3'h4, 32'h000C);
    xl(1'b0, 1'b0, 3'h3, 32'h123);
    chk(xl_paddr, 32'h0040_5123, "global base");
    xl(1'b0, 1'b0, 3'h4, 32'h10);
    chk(xl_paddr, 32'h1234_8010, "local base");
    poke(32'h1010, 32'h0);
    xl(1'b0, 1'b0, 3'h3, 32'h123);
    chk(xl_paddr, 32'h0040_5123, "cached base");
    $display("protected done");
  endtask
  task automatic t_page();
    poke(32'h0001_0004, 32'h0002_0007);
    poke(32'h0002_0014, 32'h0030_0E1F);
    apb(1'b1, AUT_DIRBASE_OFS, 32'h0001_0000);
    pg(5'h03, 1'b0, 32'hABC, 1'b0, 32'h0030_0ABC);
    chk(xl_nocache, 1'b1, "uncacheable");
    chk(peek(32'h0001_0004), 32'h0002_0027, "dir accessed");
    chk(peek(32'h0002_0014), 32'h0030_0E3F, "table accessed");
    slow <= 1'b1;
    pg(5'h03, 1'b1, 32'hABC, 1'b0, 32'h0030_0ABC);
    chk(peek(32'h0002_0014), 32'h0030_0E7F, "dirty");
    slow <= 1'b0;
    pg(5'h03, 1'b0, 32'h1ABC, 1'b1, 32'h0);
    pg(5'h03, 1'b0, 32'h0040_0ABC, 1'b1, 32'h0);
    poke(32'h0002_0014, 32'h0030_0E7B);
    pg(5'h1B, 1'b0, 32'hABC, 1'b1, 32'h0);
    apb(1'b0, AUT_STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_0008, "status page fault");
    pg(5'h13, 1'b0, 32'hABC, 1'b0, 32'h0030_0ABC);
    poke(32'h0002_0014, 32'h0030_0E7D);
    pg(5'h03, 1'b1, 32'hABC, 1'b1, 32'h0);
    pg(5'h03, 1'b0, 32'hABC, 1'b0, 32'h0030_0ABC);
    poke(32'h0002_0014, 32'h0030_0E6F);
    pg(5'h03, 1'b0, 32'hABC, 1'b0, 32'h0030_0ABC);
    chk(xl_nocache, 1'b0, "cacheable");
    $display("paging done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_real();
    t_prot();
    t_page();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
